// *** include/bt_pkg.sv ***
// Package of constants and types for the basic timer with RTC.
`default_nettype none
package bt_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'hd8;
  localparam logic [7:0] ADDR_COUNT = 8'hd9;
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'hc8;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int MODE_RUN_BIT = 7;
  localparam int MODE_RATE_HI = 6;
  localparam int MODE_RATE_LO = 4;
  localparam int MODE_RTC_BIT = 0;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;

  // ------------------------------------------------------------
  // Reset values and mode write mask
  // ------------------------------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] MODE_WRITE_MASK = 8'hf1;

  // ------------------------------------------------------------
  // Counting constants and interrupt vector address
  // ------------------------------------------------------------
  localparam logic [7:0] COUNT_FULL = 8'hff;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  localparam logic [7:0] PRESCALE_BASE_MASK = 8'hff;
  localparam int RTC_CLOCK_HZ = 32768;
  localparam int RTC_DIVIDE = 64;
  localparam logic [5:0] RTC_DIV_LAST = 6'(RTC_DIVIDE - 1);
  localparam logic [9:0] IRQ_VECTOR_ADDR = 10'h008;

  // ------------------------------------------------------------
  // Register bus carrier
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bt_bus_t;

endpackage : bt_pkg
`default_nettype wire

// *** core/bt_tick_gen.sv ***
// Count clock generator: instruction clock prescaler and RTC divider.
`default_nettype none
module bt_tick_gen (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic run,
  input wire logic fcpu_tick,
  input wire logic rtc_clk,
  input wire logic rtc_sel,
  input wire logic rtc_option_en,
  input wire logic [2:0] rate,
  output logic tick
);

  logic [7:0] pre_q, pre_d;
  logic [5:0] rtc_div_q, rtc_div_d;
  logic rtc_prev_q, rtc_prev_d;
  logic tick_q, tick_d;
  logic [7:0] mask;
  logic rtc_rise;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    mask = bt_pkg::PRESCALE_BASE_MASK >> rate;
    rtc_rise = rtc_clk && !rtc_prev_q;
    pre_d = pre_q;
    rtc_div_d = rtc_div_q;
    rtc_prev_d = rtc_clk;
    tick_d = 1'b0;
    if (!run)
    begin
      pre_d = 8'h00;
      rtc_div_d = 6'h00;
    end
    else if (rtc_sel)
    begin
      // The crystal path exists only with the RTC clock option.
      if (rtc_option_en && rtc_rise)
      begin
        rtc_div_d = rtc_div_q + 6'h01;
        tick_d = (rtc_div_q == bt_pkg::RTC_DIV_LAST);
      end
    end
    else if (fcpu_tick)
    begin
      pre_d = pre_q + 8'h01;
      tick_d = ((pre_q & mask) == mask);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pre_q <= 8'h00;
      rtc_div_q <= 6'h00;
      rtc_prev_q <= 1'b0;
      tick_q <= 1'b0;
    end
    else if (ce)
    begin
      pre_q <= pre_d;
      rtc_div_q <= rtc_div_d;
      rtc_prev_q <= rtc_prev_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_rtc_needs_option;
    @(posedge clk) disable iff (reset)
    (ce && rtc_sel && !rtc_option_en) |=> !tick_q;
  endproperty
  a_rtc_needs_option: assert property (p_rtc_needs_option) else $error("rtc tick without option");

endmodule : bt_tick_gen
`default_nettype wire

// *** core/bt_timer.sv ***
// Basic 8-bit up timer with prescaler, RTC source, flag and wake request.
`default_nettype none

// Summary of operation
// - Eight-bit counter steps once per count clock.
// - Run bit seven starts and stops counting.
// - Roll from FF to 00 sets sticky flag.
// - No reload; counting continues from zero.
// - Enabled overflow requests vector at address eight.
// - Green mode counts and overflow wakes system.
// - Same behaviour in normal and slow modes.
// - Prescale field divides instruction clock 256 to 2.
// - Bit zero selects crystal over sixty-four.
// - Crystal path needs the RTC clock option.
// - RTC mode ignores prescale, fixed half second.
// - Count register loads on write, reads live.
// - Flag sets regardless; enable gates the request.
module bt_timer (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire bt_pkg::bt_bus_t bus,
  output logic [7:0] rdata,
  input wire logic fcpu_tick,
  input wire logic rtc_clk,
  input wire logic rtc_option_en,
  input wire logic green_mode,
  output logic irq_req,
  output logic [9:0] irq_vector,
  output logic overflow_pulse,
  output logic wake_req
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0] mode_q, mode_d;
  logic [7:0] count_q, count_d;
  logic flag_q, flag_d;
  logic ien_q, ien_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic [9:0] vec_q, vec_d;
  logic ovf_q, ovf_d;
  logic wake_q, wake_d;
  logic tick;
  logic run;
  logic wr_mode, wr_count, wr_irq;
  logic overflow;

  assign run = mode_q[bt_pkg::MODE_RUN_BIT];
  assign wr_mode = bus.wr && (bus.addr == bt_pkg::ADDR_MODE);
  assign wr_count = bus.wr && (bus.addr == bt_pkg::ADDR_COUNT);
  assign wr_irq = bus.wr && (bus.addr == bt_pkg::ADDR_IRQ_CTRL);

  // ------------------------------------------------------------
  // Count clock
  // ------------------------------------------------------------
  bt_tick_gen u_tick (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .run(run),
    .fcpu_tick(fcpu_tick),
    .rtc_clk(rtc_clk),
    .rtc_sel(mode_q[bt_pkg::MODE_RTC_BIT]),
    .rtc_option_en(rtc_option_en),
    .rate(mode_q[bt_pkg::MODE_RATE_HI:bt_pkg::MODE_RATE_LO]),
    .tick(tick)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    mode_d = mode_q;
    count_d = count_q;
    flag_d = flag_q;
    ien_d = ien_q;
    overflow = 1'b0;
    if (wr_mode)
    begin
      mode_d = bus.wdata & bt_pkg::MODE_WRITE_MASK;
    end
    // The counter behaves alike in normal, slow and green modes.
    if (wr_count)
    begin
      count_d = bus.wdata;
    end
    else if (run && tick)
    begin
      count_d = count_q + bt_pkg::COUNT_STEP;
      overflow = (count_q == bt_pkg::COUNT_FULL);
    end
    if (wr_irq)
    begin
      ien_d = bus.wdata[bt_pkg::IRQ_EN_BIT];
      if (!bus.wdata[bt_pkg::IRQ_FLAG_BIT])
      begin
        flag_d = 1'b0;
      end
    end
    // A new overflow wins over a clear in the same cycle.
    if (overflow)
    begin
      flag_d = 1'b1;
    end
  end

  always_comb
  begin
    irq_d = flag_q && ien_q;
    vec_d = (flag_q && ien_q) ? bt_pkg::IRQ_VECTOR_ADDR : 10'h000;
    ovf_d = overflow;
    wake_d = overflow && green_mode;
    rdata_d = 8'h00;
    if (bus.rd)
    begin
      unique case (bus.addr)
        bt_pkg::ADDR_MODE: rdata_d = mode_q;
        bt_pkg::ADDR_COUNT: rdata_d = count_q;
        bt_pkg::ADDR_IRQ_CTRL: rdata_d = {6'h00, ien_q, flag_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_q <= bt_pkg::MODE_RESET;
      count_q <= bt_pkg::COUNT_RESET;
      flag_q <= 1'b0;
      ien_q <= 1'b0;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      vec_q <= 10'h000;
      ovf_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else if (ce)
    begin
      mode_q <= mode_d;
      count_q <= count_d;
      flag_q <= flag_d;
      ien_q <= ien_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      vec_q <= vec_d;
      ovf_q <= ovf_d;
      wake_q <= wake_d;
    end
  end

  assign rdata = rdata_q;
  assign irq_req = irq_q;
  assign irq_vector = vec_q;
  assign overflow_pulse = ovf_q;
  assign wake_req = wake_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_count_step;
    @(posedge clk) disable iff (reset)
    (ce && run && tick && !wr_count) |=> (count_q == $past(count_q) + 8'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step");

  property p_stopped_holds;
    @(posedge clk) disable iff (reset)
    (ce && !run && !wr_count) |=> (count_q == $past(count_q));
  endproperty
  a_stopped_holds: assert property (p_stopped_holds) else $error("stopped count moved");

  property p_overflow_flag;
    @(posedge clk) disable iff (reset)
    (ce && run && tick && !wr_count && count_q == 8'hff) |=> (flag_q && ovf_q);
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("overflow lost");

  property p_no_reload;
    @(posedge clk) disable iff (reset)
    (ce && overflow) |=> (count_q == 8'h00);
  endproperty
  a_no_reload: assert property (p_no_reload) else $error("count reloaded");

  property p_vector;
    @(posedge clk) disable iff (reset)
    (ce && flag_q && ien_q) |=> (irq_q && vec_q == 10'h008);
  endproperty
  a_vector: assert property (p_vector) else $error("vector not requested");

  property p_masked;
    @(posedge clk) disable iff (reset)
    (ce && !ien_q) |=> !irq_q;
  endproperty
  a_masked: assert property (p_masked) else $error("masked request raised");

  property p_wake;
    @(posedge clk) disable iff (reset)
    (ce && overflow && green_mode) |=> wake_q ##1 (!wake_q || $past(overflow));
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on overflow");

  property p_count_write;
    @(posedge clk) disable iff (reset)
    (ce && wr_count) |=> (count_q == $past(bus.wdata));
  endproperty
  a_count_write: assert property (p_count_write) else $error("count write lost");

  property p_write_wins;
    @(posedge clk) disable iff (reset)
    (ce && wr_count && run && tick) |=> (count_q == $past(bus.wdata) && !ovf_q);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("increment beat write");

  property p_mode_unused;
    @(posedge clk) disable iff (reset)
    (ce && bus.rd && bus.addr == 8'hd8) |=> (rdata_q[3:1] == 3'h0);
  endproperty
  a_mode_unused: assert property (p_mode_unused) else $error("unused mode bits set");

  property p_flag_sticky;
    @(posedge clk) disable iff (reset)
    (ce && flag_q && !wr_irq) |=> flag_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared without write");

  property p_flag_clear;
    @(posedge clk) disable iff (reset)
    (ce && wr_irq && !bus.wdata[bt_pkg::IRQ_FLAG_BIT] && !overflow) |=> !flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear lost");

  property p_set_wins;
    @(posedge clk) disable iff (reset)
    (ce && overflow && wr_irq) |=> flag_q;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat overflow");

  property p_ovf_single;
    @(posedge clk) disable iff (reset)
    (ce && ovf_q) |=> !ovf_q;
  endproperty
  a_ovf_single: assert property (p_ovf_single) else $error("overflow pulse too long");

  property p_wake_single;
    @(posedge clk) disable iff (reset)
    (ce && wake_q) |=> !wake_q;
  endproperty
  a_wake_single: assert property (p_wake_single) else $error("wake pulse too long");

  property p_wake_source;
    @(posedge clk) disable iff (reset)
    (ce && wake_q) |-> ovf_q;
  endproperty
  a_wake_source: assert property (p_wake_source) else $error("wake without overflow");

  property p_request_idle;
    @(posedge clk) disable iff (reset)
    (ce && !(flag_q && ien_q)) |=> (!irq_q && vec_q == 10'h000);
  endproperty
  a_request_idle: assert property (p_request_idle) else $error("request without enabled flag");

  property p_stopped_no_tick;
    @(posedge clk) disable iff (reset)
    (ce && !run) |=> !tick;
  endproperty
  a_stopped_no_tick: assert property (p_stopped_no_tick) else $error("tick while stopped");

  property p_stopped_no_ovf;
    @(posedge clk) disable iff (reset)
    (ce && !run) |=> !ovf_q;
  endproperty
  a_stopped_no_ovf: assert property (p_stopped_no_ovf) else $error("overflow while stopped");

  property p_mode_write;
    @(posedge clk) disable iff (reset)
    (ce && wr_mode) |=> (mode_q == ($past(bus.wdata) & bt_pkg::MODE_WRITE_MASK));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");

  property p_count_read;
    @(posedge clk) disable iff (reset)
    (ce && bus.rd && bus.addr == bt_pkg::ADDR_COUNT) |=> (rdata_q == $past(count_q));
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read wrong");

  property p_read_idle;
    @(posedge clk) disable iff (reset)
    (ce && !bus.rd) |=> (rdata_q == 8'h00);
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data without read");

endmodule : bt_timer
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking testbench for the basic timer with RTC.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  bt_pkg::bt_bus_t bus = '0;
  logic [7:0] rdata;
  logic fcpu_tick = 1'b0;
  logic rtc_clk = 1'b0;
  logic rtc_option_en = 1'b0;
  logic green_mode = 1'b0;
  logic irq_req;
  logic overflow_pulse;
  logic wake_req;
  logic [9:0] irq_vector;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic rtc_half = 1'b0;
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 44;
  int r;
  int k;

  bt_timer u_bt_timer (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .bus(bus),
    .rdata(rdata),
    .fcpu_tick(fcpu_tick),
    .rtc_clk(rtc_clk),
    .rtc_option_en(rtc_option_en),
    .green_mode(green_mode),
    .irq_req(irq_req),
    .irq_vector(irq_vector),
    .overflow_pulse(overflow_pulse),
    .wake_req(wake_req)
  );

  // ------------------------------------------------------------
  // Clock, free running crystal and read monitor
  // ------------------------------------------------------------
  initial
  begin
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (rd_seen)
    begin
      chk("rdata", {2'b00, rdata}, {2'b00, exp_q.pop_front()});
    end
    rd_seen = bus.rd;
    rtc_half <= ~rtc_half;
    if (rtc_half)
    begin
      rtc_clk <= ~rtc_clk;
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    if (exp_q.size() != 0)
      n_mismatch++;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus.addr <= a;
    bus.rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic wait_ovf();
    int i;
    for (i = 0; i < 2000 && overflow_pulse !== 1'b1; i++) @(posedge clk);
    if (i == 2000)
    begin
      n_mismatch++;
      end_sim();
    end
    else
      chk("wake_req", {9'h000, wake_req}, {9'h000, green_mode});
  endtask : wait_ovf

  // Reads the count midway between increments, m steps after an overflow.
  task automatic measure(input int div, input logic [7:0] m);
    repeat (div * m + div / 2 - 2) @(posedge clk);
    rd(bt_pkg::ADDR_COUNT, m);
  endtask : measure

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    fcpu_tick <= 1'b1;
    @(posedge clk);
    rd(bt_pkg::ADDR_MODE, bt_pkg::MODE_RESET);
    rd(bt_pkg::ADDR_COUNT, bt_pkg::COUNT_RESET);
    rd(8'h10, 8'h00);
    wr(bt_pkg::ADDR_MODE, 8'h7f);
    rd(bt_pkg::ADDR_MODE, 8'h71);
    r = $random(seed);
    wr(bt_pkg::ADDR_COUNT, r[7:0]);
    repeat (20) @(posedge clk);
    rd(bt_pkg::ADDR_COUNT, r[7:0]);
    for (k = 0; k < 8; k++)
    begin
      green_mode <= k[0];
      wr(bt_pkg::ADDR_MODE, {1'b0, k[2:0], 4'h0});
      wr(bt_pkg::ADDR_COUNT, 8'hff);
      wr(bt_pkg::ADDR_MODE, {1'b1, k[2:0], 4'h0});
      wait_ovf();
      measure(256 >> k, 8'h02);
    end
    wr(bt_pkg::ADDR_MODE, 8'h00);
    rd(bt_pkg::ADDR_IRQ_CTRL, 8'h01);
    chk("irq_req", {9'h000, irq_req}, 10'h000);
    wr(bt_pkg::ADDR_IRQ_CTRL, 8'h03);
    repeat (2) @(posedge clk);
    chk("irq_req", {9'h000, irq_req}, 10'h001);
    chk("irq_vector", irq_vector, bt_pkg::IRQ_VECTOR_ADDR);
    wr(bt_pkg::ADDR_IRQ_CTRL, 8'h02);
    repeat (2) @(posedge clk);
    chk("irq_req", {9'h000, irq_req}, 10'h000);
    rd(bt_pkg::ADDR_IRQ_CTRL, 8'h02);
    wr(bt_pkg::ADDR_COUNT, 8'hff);
    wr(bt_pkg::ADDR_MODE, 8'hf0);
    wait_ovf();
    wr(bt_pkg::ADDR_COUNT, 8'h50);
    rd(bt_pkg::ADDR_COUNT, 8'h50);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    ce <= 1'b1;
    rd(bt_pkg::ADDR_COUNT, 8'h51);
    wr(bt_pkg::ADDR_MODE, 8'h00);
    wr(bt_pkg::ADDR_COUNT, 8'hff);
    wr(bt_pkg::ADDR_MODE, 8'h81);
    repeat (600) @(posedge clk);
    rd(bt_pkg::ADDR_COUNT, 8'hff);
    r = $random(seed);
    wr(bt_pkg::ADDR_MODE, {1'b0, r[2:0], 4'h1});
    rtc_option_en <= 1'b1;
    wr(bt_pkg::ADDR_COUNT, 8'hff);
    wr(bt_pkg::ADDR_MODE, {1'b1, r[2:0], 4'h1});
    wait_ovf();
    measure(256, 8'h01);
    wr(bt_pkg::ADDR_IRQ_CTRL, 8'h02);
    rd(bt_pkg::ADDR_IRQ_CTRL, 8'h02);
    @(posedge clk);
    end_sim();
  end
endmodule : tb
`default_nettype wire
